// File: core/chs_device.sv
// Device end: halt state controller for stop, wait, one-wait, ready and hold.
`timescale 1ns/1ps
module chs_device (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	chs_if.dev LINK,
	output logic [11:0] WDT_COUNT,
	output logic WDT_SLOW_SRC,
	output logic [1:0] STATE_CODE
);
	// ==========================================================
	// Internal state.
	chs_pkg::chs_state_t state;
	chs_pkg::chs_state_t next_state;
	logic [4:0] wdt_pre;
	logic [1:0] strobe_cnt;
	logic strobe_low;
	logic clk_div;
	logic halted;
	logic wdt_tick;
	logic [4:0] pre_limit;
	logic stop_entry;

	// ==========================================================
	// Decoders shared by the processes below.

	// True in every state in which the CPU executes no code.
	// Settle counts as halted: the oscillator runs but code must still wait.
	function automatic logic is_halted(input chs_pkg::chs_state_t s);
		return (s != chs_pkg::CHS_RUN);
	endfunction : is_halted

	// True in the states after which a hardware reset keeps memory.
	// Settle is still part of stop, so a reset during oscillator start-up keeps it too.
	function automatic logic keeps_ram(input chs_pkg::chs_state_t s);
		return (s == chs_pkg::CHS_STOP) || (s == chs_pkg::CHS_SETTLE) ||
			(s == chs_pkg::CHS_WAIT);
	endfunction : keeps_ram

	// Next watchdog count; the counter wraps to all ones while code runs.
	function automatic logic [11:0] wdt_next(input logic [11:0] count);
		return (count == 12'h000) ? chs_pkg::WDT_PRELOAD : count - 12'h001;
	endfunction : wdt_next

	// True once the strobe low phase has lasted long enough.
	// A wait bit that changes mid-access still ends the phase, never hangs it.
	function automatic logic strobe_done(input logic [1:0] cnt, input logic no_wait);
		if (no_wait) begin
			return (cnt >= 2'(chs_pkg::STROBE_LOW_BASE));
		end
		return (cnt >= 2'(chs_pkg::STROBE_LOW_ONE_WAIT));
	endfunction : strobe_done

	// ==========================================================
	// State selection. Hold and ready sit on top of the run state.
	always_comb begin
		next_state = state;
		unique case (state)
			chs_pkg::CHS_RUN: begin
				// Stop wins when both instructions arrive together.
				if (LINK.stop_instruction) begin
					next_state = chs_pkg::CHS_STOP;
				end else if (LINK.wait_instruction) begin
					next_state = chs_pkg::CHS_WAIT;
				end
			end
			chs_pkg::CHS_STOP: begin
				// Only an enabled wake source may restart the oscillator.
				if (LINK.wake_pending) begin
					next_state = chs_pkg::CHS_SETTLE;
				end
			end
			chs_pkg::CHS_SETTLE: begin
				// The preloaded counter must run out before code resumes.
				if (WDT_COUNT == '0 && wdt_tick) begin
					next_state = chs_pkg::CHS_RUN;
				end
			end
			chs_pkg::CHS_WAIT: begin
				// Any accepted interrupt ends wait; the wake filter applies to stop only.
				if (LINK.irq_pending) begin
					next_state = chs_pkg::CHS_RUN;
				end
			end
			default: next_state = chs_pkg::CHS_RUN;
		endcase
	end

	// State register; every reset returns to run.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state <= chs_pkg::CHS_RUN;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// RAM keep flag: set only while stop, settle or wait so a reset then preserves memory.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.ram_keep <= 1'b0;
		end else begin
			LINK.ram_keep <= keeps_ram(next_state);
		end
	end

	// ==========================================================
	// Watchdog prescaler and counter; stopped in stop and hold.
	assign pre_limit = WDT_SLOW_SRC ? 5'(chs_pkg::WDT_DIV_SLOW - 1) :
		5'(chs_pkg::WDT_DIV_FAST - 1);
	assign wdt_tick = (wdt_pre == pre_limit);
	assign LINK.wdt_run = (state != chs_pkg::CHS_STOP) && LINK.hold_n;
	// Stop entry is decoded once so the watchdog and the clock output agree on it.
	assign stop_entry = (state == chs_pkg::CHS_RUN) && (next_state == chs_pkg::CHS_STOP);

	// The preload also clears the prescaler, so the first slow tick is a full one.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			wdt_pre <= '0;
			WDT_COUNT <= chs_pkg::WDT_PRELOAD;
			WDT_SLOW_SRC <= 1'b0;
		end else if (stop_entry) begin
			wdt_pre <= '0;
			WDT_COUNT <= chs_pkg::WDT_PRELOAD;
			WDT_SLOW_SRC <= 1'b1;
		end else if (LINK.wdt_run) begin
			wdt_pre <= wdt_tick ? 5'h00 : wdt_pre + 5'h01;
			if (wdt_tick) begin
				WDT_COUNT <= wdt_next(WDT_COUNT);
			end
		end
	end

	// ==========================================================
	// Oscillator and peripheral gating. Peripherals need the oscillator.
	assign LINK.osc_run = (state != chs_pkg::CHS_STOP);
	assign LINK.periph_run = LINK.osc_run;
	assign halted = is_halted(state);
	assign LINK.cpu_run = !halted && LINK.ready_n && LINK.hold_n;
	// The freeze covers every halted state as well as a ready stall or a hold.
	assign LINK.pins_frozen = halted || !LINK.ready_n || !LINK.hold_n;
	// Only hold floats the bus; a ready stall keeps driving the stalled access.
	assign LINK.bus_float = !LINK.hold_n;
	assign STATE_CODE = 2'(state);

	// ==========================================================
	// Clock output divider; parked low while the oscillator is stopped.
	// It is cleared on the entry edge already, so the pin is low in the first stop cycle.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			clk_div <= 1'b0;
		end else if (!LINK.osc_run || stop_entry) begin
			clk_div <= 1'b0;
		end else begin
			clk_div <= !clk_div;
		end
	end
	assign LINK.clock_out = clk_div;

	// ==========================================================
	// Strobe generator. One-wait doubles the low phase; frozen states keep level.
	// Hold wins over the freeze so the strobe is parked high for the new master.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			strobe_low <= 1'b0;
			strobe_cnt <= '0;
		end else if (!LINK.hold_n) begin
			strobe_low <= 1'b0;
			strobe_cnt <= '0;
		end else if (LINK.pins_frozen) begin
			strobe_low <= strobe_low;
		end else if (strobe_low) begin
			if (strobe_done(strobe_cnt, LINK.wait_bit)) begin
				strobe_low <= 1'b0;
				strobe_cnt <= '0;
			end else begin
				strobe_cnt <= strobe_cnt + 2'h1;
			end
		end else if (LINK.access_req) begin
			strobe_low <= 1'b1;
			strobe_cnt <= 2'h1;
		end
	end
	assign LINK.strobe_n = !strobe_low;

	// ==========================================================
	// Latch enable pulses at the start of an access, never during hold or a freeze.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.addr_latch <= 1'b0;
		end else begin
			LINK.addr_latch <= LINK.hold_n && !LINK.pins_frozen &&
				LINK.access_req && !strobe_low;
		end
	end

	// ==========================================================
	// Hold acknowledge is active low: high while the bus is ours, low in hold.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.bus_hold_acknowledge <= 1'b1;
		end else begin
			LINK.bus_hold_acknowledge <= LINK.hold_n;
		end
	end
endmodule : chs_device

// File: core/chs_pkg.sv
// Package of constants and types shared by the halt state controller ends.
package chs_pkg;
	// ==========================================================
	// Widths and reset values.
	localparam int WDT_W = 12;
	localparam logic [11:0] WDT_PRELOAD = 12'hfff;
	localparam int WDT_DIV_SLOW = 32;
	localparam int WDT_DIV_FAST = 16;
	localparam int STROBE_LOW_BASE = 1;
	localparam int STROBE_LOW_ONE_WAIT = 2;
	localparam int NOP_AFTER_INTERNAL = 1;
	localparam int NOP_AFTER_EXT_NO_WAIT = 1;
	localparam int NOP_AFTER_EXT_ONE_WAIT = 3;

	// ==========================================================
	// Controller states.
	typedef enum logic [2:0] {
		CHS_RUN,
		CHS_STOP,
		CHS_SETTLE,
		CHS_WAIT
	} chs_state_t;
endpackage : chs_pkg

// File: core/chs_if.sv
// Interface joining the halt state controller and the system party.
`timescale 1ns/1ps
interface chs_if;
	logic stop_instruction;
	logic wait_instruction;
	logic wait_bit;
	logic wake_pending;
	logic irq_pending;
	logic ready_n;
	logic hold_n;
	logic bus_hold_acknowledge;
	logic bus_float;
	logic osc_run;
	logic cpu_run;
	logic periph_run;
	logic wdt_run;
	logic pins_frozen;
	logic ram_keep;
	logic strobe_n;
	logic clock_out;
	logic addr_latch;
	logic access_req;

	// ==========================================================
	// Device end drives status; system end drives requests and pins.
	modport dev (
		input stop_instruction, wait_instruction, wait_bit, wake_pending, irq_pending,
		input ready_n, hold_n, access_req,
		output bus_hold_acknowledge, bus_float, osc_run, cpu_run, periph_run,
		output wdt_run, pins_frozen, ram_keep, strobe_n, clock_out, addr_latch
	);
	modport sys (
		output stop_instruction, wait_instruction, wait_bit, wake_pending, irq_pending,
		output ready_n, hold_n, access_req,
		input bus_hold_acknowledge, bus_float, osc_run, cpu_run, periph_run,
		input wdt_run, pins_frozen, ram_keep, strobe_n, clock_out, addr_latch
	);
endinterface : chs_if

// File: core/chs_system.sv
// System end: drives instructions, wake events, ready and hold to the device.
`timescale 1ns/1ps
module chs_system (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	chs_if.sys LINK,
	input wire logic STOP_REQ,
	input wire logic WAIT_REQ,
	input wire logic WAIT_BIT,
	input wire logic WAKE_ENABLE,
	input wire logic WAKE_EVENT,
	input wire logic IRQ_EVENT,
	input wire logic STALL_REQ,
	input wire logic HOLD_REQ,
	input wire logic ACCESS_REQ,
	output logic HALT_ACCEPTED
);
	logic wake_en;
	logic [1:0] nop_cnt;

	// ==========================================================
	// Wake enable is latched first so a stop never outruns it.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			wake_en <= 1'b0;
		end else begin
			wake_en <= WAKE_ENABLE;
		end
	end

	// ==========================================================
	// Padding after an access: one slot, three in one-wait mode.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			nop_cnt <= '0;
		end else if (ACCESS_REQ) begin
			nop_cnt <= WAIT_BIT ? 2'(chs_pkg::NOP_AFTER_EXT_NO_WAIT) :
				2'(chs_pkg::NOP_AFTER_EXT_ONE_WAIT);
		end else if (nop_cnt != '0) begin
			nop_cnt <= nop_cnt - 2'h1;
		end
	end

	// ==========================================================
	// Request outputs registered so every output is defined from reset.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			LINK.stop_instruction <= 1'b0;
			LINK.wait_instruction <= 1'b0;
			LINK.wait_bit <= 1'b0;
			LINK.wake_pending <= 1'b0;
			LINK.irq_pending <= 1'b0;
			LINK.ready_n <= 1'b1;
			LINK.hold_n <= 1'b1;
			LINK.access_req <= 1'b0;
			HALT_ACCEPTED <= 1'b0;
		end else begin
			LINK.stop_instruction <= STOP_REQ && wake_en && nop_cnt == '0 && LINK.cpu_run;
			LINK.wait_instruction <= WAIT_REQ && !STOP_REQ && nop_cnt == '0 && LINK.cpu_run;
			LINK.wait_bit <= WAIT_BIT;
			LINK.wake_pending <= WAKE_EVENT && wake_en;
			LINK.irq_pending <= IRQ_EVENT;
			LINK.ready_n <= !STALL_REQ;
			LINK.hold_n <= !HOLD_REQ;
			LINK.access_req <= ACCESS_REQ && LINK.cpu_run;
			HALT_ACCEPTED <= !LINK.cpu_run;
		end
	end
endmodule : chs_system

// File: test/chs_link_monitor.sv
// Checker of the link signals between the two halt state controller ends.
`timescale 1ns/1ps
module chs_link_monitor (
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire logic wait_bit,
	input wire logic wake_pending,
	input wire logic ready_n,
	input wire logic hold_n,
	input wire logic bus_hold_acknowledge,
	input wire logic bus_float,
	input wire logic osc_run,
	input wire logic cpu_run,
	input wire logic periph_run,
	input wire logic wdt_run,
	input wire logic pins_frozen,
	input wire logic ram_keep,
	input wire logic strobe_n,
	input wire logic clock_out,
	input wire logic addr_latch
);
	// ==========================================================
	// Properties, all in the core clock domain.
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	property p_periph; !osc_run |-> !periph_run; endproperty
	a_periph: assert property (p_periph) else $error("peripherals run without oscillator");
	property p_stop_pins; !osc_run |-> !clock_out && !cpu_run && pins_frozen; endproperty
	a_stop_pins: assert property (p_stop_pins) else $error("stop leaves clock or pins live");
	property p_stop_strobe; !osc_run && $past(!osc_run) |-> $stable(strobe_n); endproperty
	a_stop_strobe: assert property (p_stop_strobe) else $error("strobe moved in stop");
	property p_stop_wdt; !osc_run |-> !wdt_run; endproperty
	a_stop_wdt: assert property (p_stop_wdt) else $error("watchdog runs in stop");
	property p_stop_exit; !osc_run && !wake_pending |=> !osc_run; endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop left without wake");
	property p_ram; $fell(osc_run) |-> ram_keep; endproperty
	a_ram: assert property (p_ram) else $error("stop entered without keeping ram");
	property p_one_wait; $fell(strobe_n) && !wait_bit |=> !strobe_n ##1 strobe_n; endproperty
	a_one_wait: assert property (p_one_wait) else $error("strobe low not doubled");
	property p_no_wait; $fell(strobe_n) && wait_bit |=> strobe_n; endproperty
	a_no_wait: assert property (p_no_wait) else $error("strobe low too long");
	property p_ready; !ready_n && osc_run |-> !cpu_run && pins_frozen && periph_run; endproperty
	a_ready: assert property (p_ready) else $error("ready stall not honoured");
	property p_hold; !hold_n |-> bus_float && !cpu_run && !wdt_run && periph_run; endproperty
	a_hold: assert property (p_hold) else $error("hold does not release bus");
	property p_hold_pins;
		!hold_n && $past(!hold_n) |-> strobe_n && !addr_latch && !bus_hold_acknowledge;
	endproperty
	a_hold_pins: assert property (p_hold_pins) else $error("hold pin levels wrong");
	property p_ack_idle; hold_n && $past(hold_n) |-> bus_hold_acknowledge; endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("acknowledge low without hold");
	// Covers show that stop, hold and the doubled strobe were reached.
	c_stop: cover property ($fell(osc_run));
	c_hold: cover property (!hold_n ##1 !hold_n);
	c_one_wait: cover property ($fell(strobe_n) && !wait_bit);
endmodule : chs_link_monitor

// File: test/cpu_halt_state_control_bench.sv
// Testbench joining both ends of the halt state controller.
`timescale 1ns/1ps
module cpu_halt_state_control_bench;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic stop_req = 1'b0, wait_req = 1'b0, wait_bit = 1'b1, wake_enable = 1'b0;
	logic wake_event = 1'b0, irq_event = 1'b0, stall_req = 1'b0, hold_req = 1'b0;
	logic access_req = 1'b0;
	logic [11:0] wdt_count;
	logic wdt_slow;
	logic [1:0] state_code;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	logic halt_accepted;
	localparam int REQ_STOP = 0;
	localparam int REQ_WAIT = 1;
	localparam int REQ_IRQ = 2;
	localparam int REQ_WAKE = 3;
	localparam int REQ_ACCESS = 4;
	chs_if link ();
	chs_device u_chs_device (.CORE_CLK(core_clk), .RSTN(rstn), .LINK(link),
		.WDT_COUNT(wdt_count), .WDT_SLOW_SRC(wdt_slow), .STATE_CODE(state_code));
	chs_system u_chs_system (.CORE_CLK(core_clk), .RSTN(rstn), .LINK(link),
		.STOP_REQ(stop_req), .WAIT_REQ(wait_req), .WAIT_BIT(wait_bit),
		.WAKE_ENABLE(wake_enable), .WAKE_EVENT(wake_event), .IRQ_EVENT(irq_event),
		.STALL_REQ(stall_req), .HOLD_REQ(hold_req), .ACCESS_REQ(access_req),
		.HALT_ACCEPTED(halt_accepted));
	chs_link_monitor u_chs_link_monitor (.CORE_CLK(core_clk), .RSTN(rstn),
		.wait_bit(link.wait_bit), .wake_pending(link.wake_pending), .ready_n(link.ready_n),
		.hold_n(link.hold_n), .bus_hold_acknowledge(link.bus_hold_acknowledge),
		.bus_float(link.bus_float), .osc_run(link.osc_run), .cpu_run(link.cpu_run),
		.periph_run(link.periph_run), .wdt_run(link.wdt_run), .pins_frozen(link.pins_frozen),
		.ram_keep(link.ram_keep), .strobe_n(link.strobe_n), .clock_out(link.clock_out),
		.addr_latch(link.addr_latch));
	// ==========================================================
	// Clock and hang guard; a stuck state would otherwise run forever.
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			give_verdict();
		end
	end
	// ==========================================================
	// Helper tasks.
	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic chkv(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chkv
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick
	// Raises one request input for a single cycle, selected by a REQ code.
	task automatic pulse(input int sel);
		@(posedge core_clk);
		set_req(sel, 1'b1);
		@(posedge core_clk);
		set_req(sel, 1'b0);
	endtask : pulse
	task automatic set_req(input int sel, input logic v);
		case (sel)
			REQ_STOP: stop_req <= v;
			REQ_WAIT: wait_req <= v;
			REQ_IRQ: irq_event <= v;
			REQ_WAKE: wake_event <= v;
			default: access_req <= v;
		endcase
	endtask : set_req
	task automatic wait_code(input logic [1:0] s);
		n = 0;
		while (state_code !== s && n < 40) begin
			tick(1);
			n++;
		end
		chkv(12'(state_code), 12'(s));
	endtask : wait_code
	// Counts strobe low cycles of one access at the given wait bit.
	task automatic access_low(input logic wb, input int exp);
		@(posedge core_clk);
		wait_bit <= wb;
		tick(2);
		pulse(REQ_ACCESS);
		n = 0;
		repeat (10) begin
			#1;
			if (link.strobe_n === 1'b0) n++;
			@(posedge core_clk);
		end
		chkv(12'(n), 12'(exp));
	endtask : access_low
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	// ==========================================================
	// Main sequence.
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		tick(2);
		chkv(12'(state_code), 12'h000);
		chk1(link.bus_hold_acknowledge, 1'b1);
		access_low(1'b1, 1);
		access_low(1'b0, 2);
		wait_bit <= 1'b1;
		tick(4);
		pulse(REQ_WAIT);
		wait_code(2'h3);
		chk1(link.periph_run, 1'b1);
		chk1(link.ram_keep, 1'b1);
		pulse(REQ_IRQ);
		wait_code(2'h0);
		@(posedge core_clk);
		stall_req <= 1'b1;
		tick(3);
		chk1(link.cpu_run, 1'b0);
		chk1(link.pins_frozen, 1'b1);
		@(posedge core_clk);
		stall_req <= 1'b0;
		hold_req <= 1'b1;
		tick(3);
		chk1(link.bus_float, 1'b1);
		chk1(link.wdt_run, 1'b0);
		chk1(link.strobe_n, 1'b1);
		chk1(link.addr_latch, 1'b0);
		chk1(link.bus_hold_acknowledge, 1'b0);
		@(posedge core_clk);
		hold_req <= 1'b0;
		tick(3);
		chk1(link.bus_float, 1'b0);
		chk1(link.bus_hold_acknowledge, 1'b1);
		pulse(REQ_STOP);
		tick(4);
		chkv(12'(state_code), 12'h000);
		@(posedge core_clk);
		wake_enable <= 1'b1;
		pulse(REQ_STOP);
		wait_code(2'h1);
		chk1(link.osc_run, 1'b0);
		chk1(link.clock_out, 1'b0);
		chk1(link.pins_frozen, 1'b1);
		chkv(wdt_count, 12'hfff);
		chk1(wdt_slow, 1'b1);
		chk1(link.wdt_run, 1'b0);
		chk1(link.periph_run, 1'b0);
		chk1(link.ram_keep, 1'b1);
		pulse(REQ_IRQ);
		tick(4);
		chkv(12'(state_code), 12'h001);
		pulse(REQ_WAKE);
		wait_code(2'h2);
		tick(100);
		chk1(link.cpu_run, 1'b0);
		chk1(halt_accepted, 1'b1);
		chk1(link.ram_keep, 1'b1);
		@(posedge core_clk);
		rstn <= 1'b0;
		tick(2);
		@(posedge core_clk);
		rstn <= 1'b1;
		tick(2);
		chkv(12'(state_code), 12'h000);
		chk1(link.ram_keep, 1'b0);
		chk1(halt_accepted, 1'b0);
		give_verdict();
	end
endmodule : cpu_halt_state_control_bench
